// *** shared/fppec_defines.svh ***
// Purpose: offsets, fields, commands, reset values and timing of the flash sequencer
// Assumes: register index times four is the byte address on the bus
// Notes: definitions only
`ifndef FPPEC_DEFINES_SVH
`define FPPEC_DEFINES_SVH

// register indexes (byte address is index * 4)
`define FPPEC_IDX_CTL 12'hFF8
`define FPPEC_IDX_PAGE 12'hFF9
`define FPPEC_IDX_FREQH 12'hFFA
`define FPPEC_IDX_FREQL 12'hFFB

// program memory window and geometry
`define FPPEC_MEM_TOP 3'h0
`define FPPEC_ADDR_W 13
`define FPPEC_PAGE_W 7
`define FPPEC_SECTORS 8

// control commands
`define FPPEC_CMD_UNLK1 8'h73
`define FPPEC_CMD_UNLK2 8'h8C
`define FPPEC_CMD_PERASE 8'h95
`define FPPEC_CMD_MERASE 8'h63
`define FPPEC_CMD_PROT 8'h5E

// controller state field codes
`define FPPEC_ST_LOCKED 6'h00
`define FPPEC_ST_UNLK1 6'h01
`define FPPEC_ST_UNLK2 6'h02
`define FPPEC_ST_UNLOCKED 6'h03
`define FPPEC_ST_PROT 6'h04
`define FPPEC_ST_PROG 6'h08
`define FPPEC_ST_PERASE 6'h10
`define FPPEC_ST_MERASE 6'h20

// reset values
`define FPPEC_RST_BYTE 8'h00
`define FPPEC_RST_PROT 8'h00

// operation times in microseconds, converted at run time from clock_khz_value
`define FPPEC_PROG_TIME_US 18'h00028
`define FPPEC_PERASE_TIME_US 18'h02710
`define FPPEC_MERASE_TIME_US 18'h30D40
`define FPPEC_KHZ_PER_MHZ 17'h003E8

`endif

// *** shared/fppec_pkg.sv ***
// Purpose: types shared by the flash sequencer files
// Assumes: nothing beyond the defines header
// Notes: nothing is imported by users
package fppec_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_LOCKED,
    ST_UNLK1,
    ST_UNLK2,
    ST_UNLOCKED,
    ST_PROT_SEL,
    ST_PROG,
    ST_PERASE,
    ST_MERASE
  } fppec_state_t;

  // request toward the flash array
  typedef struct packed {
    logic rd;
    logic prog;
    logic page_erase;
    logic mass_erase;
    logic [12:0] addr;
    logic [7:0] wdata;
  } fppec_arr_req_t;

endpackage

// *** hdl/fppec_timer.sv ***
// Purpose: times program and erase operations from the clock rate in kilohertz
// Assumes: clock_khz_value holds the system clock rate in kHz
// Notes: a rate of zero ticks every cycle
`include "fppec_defines.svh"

module fppec_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [17:0] dur_us,
  input wire logic [15:0] clock_khz_value,
  output logic busy,
  output logic done
);
  logic [16:0] acc_q;
  logic [17:0] cnt_q;
  logic [16:0] acc_sum;
  logic tick;

  // one microsecond passes each time the accumulator wraps the rate
  assign acc_sum = acc_q + `FPPEC_KHZ_PER_MHZ;
  assign tick = acc_sum >= {1'b0, clock_khz_value};

  // microsecond accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 17'h00000;
    end else if (start) begin
      acc_q <= 17'h00000;
    end else if (busy) begin
      acc_q <= tick ? acc_sum - {1'b0, clock_khz_value} : acc_sum;
    end
  end

  // remaining microseconds and completion pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 18'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= dur_us;
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_q <= 18'h00001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 18'h00001;
        end
      end
    end
  end
endmodule

// *** hdl/fppec_top.sv ***
// Purpose: protection and program/erase sequencing of an on-chip flash controller
// Assumes: one AHB-Lite master; dbg_access marks transfers made by the debugger
// Notes: the flash array performs the cell operations; this block times and guards them
`include "fppec_defines.svh"

module fppec_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic dbg_access,
  input wire logic readout_protect_option,
  input wire logic high_side_write_option,
  input wire logic write_protect_option,
  input wire logic [7:0] arr_rdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output fppec_pkg::fppec_arr_req_t arr_req,
  output logic cpu_stall
);
  fppec_pkg::fppec_state_t state_q;
  fppec_pkg::fppec_state_t state_d;
  logic ap_valid_q;
  logic ap_write_q;
  logic ap_dbg_q;
  logic [15:0] ap_addr_q;
  logic [6:0] page_q;
  logic info_en_q;
  logic [7:0] prot_q;
  logic [15:0] khz_q;
  logic rd_pend_q;
  logic [12:0] rd_addr_q;
  logic [1:0] rd_step_q;
  logic accept;
  logic is_mem;
  logic is_reg;
  logic wr_now;
  logic wr_ctl;
  logic wr_page;
  logic wr_freqh;
  logic wr_freql;
  logic wr_mem;
  logic [7:0] wbyte;
  logic busy;
  logic op_start;
  logic [17:0] op_dur;
  logic tmr_done;
  logic page_ok;
  logic prog_ok;
  logic [5:0] state_code;
  logic [31:0] reg_rdata;

  // address phase decode
  assign accept = hsel && htrans[1] && hready;
  assign is_mem = haddr[15:13] == `FPPEC_MEM_TOP;
  assign is_reg = haddr[15:14] == 2'h0 && haddr[13:4] == 10'(`FPPEC_IDX_CTL >> 2);

  // data phase write strobes
  assign wr_now = ap_valid_q && ap_write_q;
  assign wbyte = hwdata[7:0];
  assign wr_ctl = wr_now && ap_addr_q[15:2] == {2'h0, `FPPEC_IDX_CTL};
  assign wr_page = wr_now && ap_addr_q[15:2] == {2'h0, `FPPEC_IDX_PAGE};
  assign wr_freqh = wr_now && ap_addr_q[15:2] == {2'h0, `FPPEC_IDX_FREQH};
  assign wr_freql = wr_now && ap_addr_q[15:2] == {2'h0, `FPPEC_IDX_FREQL};
  assign wr_mem = wr_now && ap_addr_q[15:13] == `FPPEC_MEM_TOP;

  assign busy = state_q == fppec_pkg::ST_PROG || state_q == fppec_pkg::ST_PERASE ||
                state_q == fppec_pkg::ST_MERASE;

  // gate by option bits, sector bits and debugger access
  function automatic logic sector_open(input logic [2:0] sector, input logic dbg);
    logic opt_ok;
    // user refused with both options clear
    opt_ok = write_protect_option || (high_side_write_option && sector[2]);
    sector_open = dbg || (opt_ok && !prot_q[sector]);
  endfunction

  always_comb page_ok = page_q[6:4] == 3'h0 && sector_open(page_q[3:1], ap_dbg_q);

  always_comb prog_ok = ap_dbg_q ||
                        ({page_q, 9'h000} == {3'h0, ap_addr_q[12:9], 9'h000} &&
                         sector_open(ap_addr_q[12:10], 1'b0));

  // sequencer next state
  always_comb begin
    state_d = state_q;
    op_start = 1'b0;
    op_dur = `FPPEC_PROG_TIME_US;
    unique case (state_q)
      fppec_pkg::ST_LOCKED: begin
        if (wr_ctl && wbyte == `FPPEC_CMD_UNLK1) begin
          state_d = fppec_pkg::ST_UNLK1;
        end
      end
      fppec_pkg::ST_UNLK1: begin
        if (wr_ctl) begin
          if (wbyte == `FPPEC_CMD_UNLK2) begin
            state_d = ap_dbg_q ? fppec_pkg::ST_UNLOCKED : fppec_pkg::ST_UNLK2;
          end else if (wbyte == `FPPEC_CMD_PROT) begin
            state_d = fppec_pkg::ST_PROT_SEL;
          end else begin
            state_d = fppec_pkg::ST_LOCKED;
          end
        end
      end
      fppec_pkg::ST_UNLK2: begin
        if (wr_ctl) begin
          state_d = fppec_pkg::ST_LOCKED;
        end else if (wr_page) begin
          state_d = wbyte[6:0] == page_q ? fppec_pkg::ST_UNLOCKED : fppec_pkg::ST_LOCKED;
        end
      end
      fppec_pkg::ST_PROT_SEL: begin
        if (wr_ctl || wr_page) begin
          state_d = fppec_pkg::ST_LOCKED;
        end
      end
      fppec_pkg::ST_UNLOCKED: begin
        if (wr_ctl) begin
          state_d = fppec_pkg::ST_LOCKED;
          if (wbyte == `FPPEC_CMD_PERASE && page_ok) begin
            state_d = fppec_pkg::ST_PERASE;
            op_start = 1'b1;
            op_dur = `FPPEC_PERASE_TIME_US;
          end else if (wbyte == `FPPEC_CMD_MERASE && ap_dbg_q) begin
            state_d = fppec_pkg::ST_MERASE;
            op_start = 1'b1;
            op_dur = `FPPEC_MERASE_TIME_US;
          end
        end else if (wr_page && !ap_dbg_q) begin
          state_d = fppec_pkg::ST_LOCKED;
        end else if (wr_mem && prog_ok) begin
          state_d = fppec_pkg::ST_PROG;
          op_start = 1'b1;
        end
      end
      fppec_pkg::ST_PROG: begin
        if (tmr_done) begin
          state_d = fppec_pkg::ST_UNLOCKED;
        end
      end
      fppec_pkg::ST_PERASE, fppec_pkg::ST_MERASE: begin
        if (tmr_done) begin
          state_d = fppec_pkg::ST_LOCKED;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= fppec_pkg::ST_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    unique case (state_q)
      fppec_pkg::ST_LOCKED: state_code = `FPPEC_ST_LOCKED;
      fppec_pkg::ST_UNLK1: state_code = `FPPEC_ST_UNLK1;
      fppec_pkg::ST_UNLK2: state_code = `FPPEC_ST_UNLK2;
      fppec_pkg::ST_UNLOCKED: state_code = `FPPEC_ST_UNLOCKED;
      fppec_pkg::ST_PROT_SEL: state_code = `FPPEC_ST_PROT;
      fppec_pkg::ST_PROG: state_code = `FPPEC_ST_PROG;
      fppec_pkg::ST_PERASE: state_code = `FPPEC_ST_PERASE;
      fppec_pkg::ST_MERASE: state_code = `FPPEC_ST_MERASE;
    endcase
  end

  // register read mux; unmapped words read zero
  always_comb begin
    reg_rdata = 32'h00000000;
    unique case (haddr[3:2])
      2'h0: reg_rdata = {26'h0000000, state_code};
      2'h1: reg_rdata = {24'h000000, info_en_q, page_q};
      2'h2: reg_rdata = {24'h000000, khz_q[15:8]};
      2'h3: reg_rdata = {24'h000000, khz_q[7:0]};
    endcase
  end

  // page select register, frozen while a page is open to user code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {info_en_q, page_q} <= `FPPEC_RST_BYTE;
    end else if (wr_page && !busy && state_q != fppec_pkg::ST_PROT_SEL &&
                 (state_q != fppec_pkg::ST_UNLOCKED || ap_dbg_q)) begin
      page_q <= wbyte[6:0];
      info_en_q <= wbyte[7];
    end
  end

  // user bits set only; debugger may clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_q <= `FPPEC_RST_PROT;
    end else if (wr_page && state_q == fppec_pkg::ST_PROT_SEL) begin
      prot_q <= ap_dbg_q ? wbyte : prot_q | wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      khz_q <= {`FPPEC_RST_BYTE, `FPPEC_RST_BYTE};
    end else if (wr_freqh) begin
      khz_q[15:8] <= wbyte;
    end else if (wr_freql) begin
      khz_q[7:0] <= wbyte;
    end
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_dbg_q <= 1'b0;
      ap_addr_q <= 16'h0000;
    end else begin
      ap_valid_q <= accept;
      if (accept) begin
        ap_write_q <= hwrite;
        ap_dbg_q <= dbg_access;
        ap_addr_q <= haddr;
      end
    end
  end

  // bus answers: registers zero wait, array reads wait for the array
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 13'h0000;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        if (is_mem && !(dbg_access && readout_protect_option)) begin
          rd_pend_q <= 1'b1;
          rd_addr_q <= haddr[12:0];
          hreadyout <= 1'b0;
        end else begin
          hrdata <= is_reg ? reg_rdata : 32'h00000000;
        end
      end else if (rd_step_q == 2'h2) begin
        hrdata <= {24'h000000, arr_rdata};
        hreadyout <= 1'b1;
      end
      if (rd_pend_q && !busy && rd_step_q == 2'h0) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // array read pacing: strobe, array latch, capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_step_q <= 2'h0;
    end else if (rd_pend_q && !busy && rd_step_q == 2'h0) begin
      rd_step_q <= 2'h1;
    end else if (rd_step_q != 2'h0) begin
      rd_step_q <= rd_step_q == 2'h2 ? 2'h0 : rd_step_q + 2'h1;
    end
  end

  // array request, held for the length of each operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arr_req <= '0;
    end else begin
      arr_req.rd <= rd_pend_q && !busy && rd_step_q == 2'h0;
      if (rd_pend_q && !busy && rd_step_q == 2'h0) begin
        arr_req.addr <= rd_addr_q;
      end
      if (op_start) begin
        // array clears bits and erases to FFH
        arr_req.prog <= state_d == fppec_pkg::ST_PROG;
        arr_req.page_erase <= state_d == fppec_pkg::ST_PERASE;
        arr_req.mass_erase <= state_d == fppec_pkg::ST_MERASE;
        arr_req.addr <= state_d == fppec_pkg::ST_PROG ? ap_addr_q[12:0] :
                        state_d == fppec_pkg::ST_PERASE ? {page_q[3:0], 9'h000} : 13'h0000;
        arr_req.wdata <= wbyte;
      end else if (tmr_done) begin
        arr_req.prog <= 1'b0;
        arr_req.page_erase <= 1'b0;
        arr_req.mass_erase <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= state_d == fppec_pkg::ST_PROG || state_d == fppec_pkg::ST_PERASE ||
                   state_d == fppec_pkg::ST_MERASE;
    end
  end

  // operation timer
  fppec_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(op_start),
    .dur_us(op_dur),
    .clock_khz_value(khz_q),
    .busy(),
    .done(tmr_done)
  );
endmodule

// *** tb/fppec_top_properties.sv ***
// Purpose: port-level checks of the flash sequencer
// Assumes: one clock, hresetn asynchronous and active low
// Notes: bound to fppec_top after the module
module fppec_top_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic dbg_access,
  input wire logic readout_protect_option,
  input wire logic high_side_write_option,
  input wire logic write_protect_option,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire fppec_pkg::fppec_arr_req_t arr_req,
  input wire logic cpu_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_stall_op: assert property (cpu_stall ==
    (arr_req.prog || arr_req.page_erase || arr_req.mass_erase))
    else $error("stall differs from running operation");
  a_single_op: assert property (
    $onehot0({arr_req.prog, arr_req.page_erase, arr_req.mass_erase}))
    else $error("two operations at once");
  a_mass_dbg_only: assert property (
    $rose(arr_req.mass_erase) |-> $past(dbg_access, 2))
    else $error("mass erase started by user code");
  a_erase_page_base: assert property (
    $rose(arr_req.page_erase) |-> arr_req.addr[8:0] == 9'h000)
    else $error("page erase address not page aligned");
  a_option_refuse: assert property (
    $rose(arr_req.prog || arr_req.page_erase) && !$past(dbg_access, 2)
    |-> write_protect_option || high_side_write_option)
    else $error("user operation with both option bits clear");
  a_read_timing: assert property (
    $rose(arr_req.rd) |-> !hreadyout ##1 !hreadyout ##1 hreadyout)
    else $error("array read answer out of time");
  a_readout_block: assert property (
    hsel && htrans[1] && hready && !hwrite && dbg_access && readout_protect_option
    && haddr < 16'h2000 |=> hreadyout && hrdata == 32'h0 && !arr_req.rd)
    else $error("protected code read by debugger");
  a_op_needs_write: assert property (
    $rose(cpu_stall) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("operation started without a write");
endmodule

bind fppec_top fppec_top_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .dbg_access(dbg_access), .readout_protect_option(readout_protect_option),
  .high_side_write_option(high_side_write_option),
  .write_protect_option(write_protect_option), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .arr_req(arr_req), .cpu_stall(cpu_stall));

// *** tb/fppec_flash_model.sv ***
// Purpose: behavioural flash array behind the sequencer
// Assumes: each operation acts when its request rises
// Notes: cells keep contents over reset, as flash does
module fppec_flash_model (
  input wire logic hclk,
  input wire fppec_pkg::fppec_arr_req_t arr_req,
  output logic [7:0] arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];
  logic rd_q = 1'b0;
  logic [12:0] addr_q = 13'h0;
  logic [7:0] last_q = 8'h00;
  fppec_pkg::fppec_arr_req_t req_q = '0;

  // start from an erased array
  initial begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'hFF;
  end

  // cell operations on rising requests
  always @(posedge hclk) begin
    rd_q <= arr_req.rd;
    addr_q <= arr_req.addr;
    req_q <= arr_req;
    if (rd_q)
      last_q <= mem[addr_q];
    if (arr_req.prog && !req_q.prog)
      mem[arr_req.addr] <= mem[arr_req.addr] & arr_req.wdata;
    if (arr_req.page_erase && !req_q.page_erase)
      for (int i = 0; i < 512; i++)
        mem[{arr_req.addr[12:9], 9'h000} + i] <= 8'hFF;
    if (arr_req.mass_erase && !req_q.mass_erase)
      for (int i = 0; i < 8192; i++)
        mem[i] <= 8'hFF;
  end

  // data only after a read pulse, else the inverse of the last byte read
  assign arr_rdata = rd_q ? mem[addr_q] : ~last_q;
endmodule

// *** tb/fppec_top_tb.sv ***
// Purpose: self-checking bench of the flash protection and sequencing block
// Assumes: clock_khz_value is zero during every operation, so one microsecond lasts one cycle
// Notes: mass erase is cut by a reset, its full length exceeds the run budget
`include "fppec_defines.svh"
module fppec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_CTL = {2'b00, `FPPEC_IDX_CTL, 2'b00};
  localparam logic [15:0] A_PG = {2'b00, `FPPEC_IDX_PAGE, 2'b00};
  localparam logic [15:0] A_KH = {2'b00, `FPPEC_IDX_FREQH, 2'b00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic dbg_access = 1'b0;
  logic ro_opt = 1'b0;
  logic hs_opt = 1'b0;
  logic wp_opt = 1'b1;
  logic [7:0] arr_rdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  fppec_pkg::fppec_arr_req_t arr_req;
  logic cpu_stall;
  logic [31:0] v;
  int err_total = 0;
  int samples_checked = 0;

  fppec_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .dbg_access(dbg_access), .readout_protect_option(ro_opt),
    .high_side_write_option(hs_opt), .write_protect_option(wp_opt),
    .arr_rdata(arr_rdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .arr_req(arr_req), .cpu_stall(cpu_stall));
  fppec_flash_model u_flash (.hclk(hclk), .arr_req(arr_req), .arr_rdata(arr_rdata));

  // system clock
  always #20 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single transfer, each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a);
    xfer(1'b0, a, 8'h00);
  endtask

  // read the state field and compare
  task automatic st(input logic [5:0] e);
    rd(A_CTL);
    chk(v, {26'h0, e});
  endtask

  task automatic unlock(input logic [7:0] pg, input logic second);
    wr(A_PG, pg);
    wr(A_CTL, `FPPEC_CMD_UNLK1);
    wr(A_CTL, `FPPEC_CMD_UNLK2);
    if (second)
      wr(A_PG, pg);
  endtask

  // bounded wait for the running operation to end
  task automatic op_end(input int lim);
    int i;
    i = 0;
    @(posedge hclk);
    while (cpu_stall !== 1'b0 && i < lim) begin
      @(posedge hclk);
      i++;
    end
    chk({31'h0, cpu_stall}, 32'h0);
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    do_reset;
    st(`FPPEC_ST_LOCKED);
    rd(A_PG);
    chk(v, 32'h0);
    wr(A_KH, 8'hAB);
    rd(A_KH);
    chk(v, 32'h0000_00AB);
    wr(A_KH, 8'h00);
    rd(16'h8000);
    chk(v, 32'h0);
    $display("test reset done");
    // unlock steps through each state code
    wr(A_PG, 8'h02);
    wr(A_CTL, `FPPEC_CMD_UNLK1);
    st(`FPPEC_ST_UNLK1);
    wr(A_CTL, `FPPEC_CMD_UNLK2);
    st(`FPPEC_ST_UNLK2);
    wr(A_PG, 8'h02);
    st(`FPPEC_ST_UNLOCKED);
    // program twice inside the open page, once outside
    wr(16'h0405, 8'hA5);
    st(`FPPEC_ST_PROG);
    chk({31'h0, cpu_stall}, 32'h1);
    op_end(60);
    st(`FPPEC_ST_UNLOCKED);
    wr(16'h0405, 8'h0F);
    op_end(60);
    wr(16'h0600, 8'h00);
    st(`FPPEC_ST_UNLOCKED);
    rd(16'h0405);
    chk(v, 32'h05);
    rd(16'h0600);
    chk(v, 32'hFF);
    wr(A_CTL, 8'h00);
    st(`FPPEC_ST_LOCKED);
    $display("test program done");
    // wrong page or wrong order stays locked
    unlock(8'h02, 1'b0);
    wr(A_PG, 8'h03);
    st(`FPPEC_ST_LOCKED);
    wr(A_CTL, `FPPEC_CMD_UNLK1);
    wr(A_CTL, `FPPEC_CMD_PERASE);
    st(`FPPEC_ST_LOCKED);
    $display("test sequence done");
    unlock(8'h02, 1'b1);
    wr(A_CTL, `FPPEC_CMD_PERASE);
    st(`FPPEC_ST_PERASE);
    op_end(10100);
    st(`FPPEC_ST_LOCKED);
    rd(16'h0405);
    chk(v, 32'hFF);
    $display("test page erase done");
    // protect sector 1, then try to clear it
    wr(A_CTL, `FPPEC_CMD_UNLK1);
    wr(A_CTL, `FPPEC_CMD_PROT);
    st(`FPPEC_ST_PROT);
    wr(A_PG, 8'h02);
    st(`FPPEC_ST_LOCKED);
    rd(A_PG);
    chk(v, 32'h02);
    wr(A_CTL, `FPPEC_CMD_UNLK1);
    wr(A_CTL, `FPPEC_CMD_PROT);
    wr(A_PG, 8'h00);
    unlock(8'h03, 1'b1);
    wr(16'h0600, 8'h00);
    st(`FPPEC_ST_UNLOCKED);
    wr(A_CTL, `FPPEC_CMD_PERASE);
    st(`FPPEC_ST_LOCKED);
    rd(16'h0600);
    chk(v, 32'hFF);
    unlock(8'h00, 1'b1);
    wr(A_CTL, `FPPEC_CMD_MERASE);
    st(`FPPEC_ST_LOCKED);
    $display("test protect done");
    // debugger skips second page write and protection
    dbg_access <= 1'b1;
    unlock(8'h03, 1'b0);
    st(`FPPEC_ST_UNLOCKED);
    wr(A_PG, 8'h01);
    st(`FPPEC_ST_UNLOCKED);
    rd(A_PG);
    chk(v, 32'h01);
    wr(16'h0600, 8'h12);
    op_end(60);
    wr(16'h0100, 8'h34);
    op_end(60);
    rd(16'h0600);
    chk(v, 32'h12);
    rd(16'h0100);
    chk(v, 32'h34);
    wr(A_CTL, `FPPEC_CMD_MERASE);
    st(`FPPEC_ST_MERASE);
    chk({31'h0, cpu_stall}, 32'h1);
    do_reset;
    st(`FPPEC_ST_LOCKED);
    $display("test debugger done");
    ro_opt <= 1'b1;
    rd(16'h0100);
    chk(v, 32'h0);
    ro_opt <= 1'b0;
    rd(16'h0100);
    chk(v, 32'hFF);
    $display("test readout done");
    // both option bits clear refuse user changes
    dbg_access <= 1'b0;
    wp_opt <= 1'b0;
    unlock(8'h00, 1'b1);
    wr(16'h0010, 8'h00);
    st(`FPPEC_ST_UNLOCKED);
    wr(A_CTL, `FPPEC_CMD_PERASE);
    st(`FPPEC_ST_LOCKED);
    rd(16'h0010);
    chk(v, 32'hFF);
    // high-side option opens the upper half to user code
    hs_opt <= 1'b1;
    unlock(8'h08, 1'b1);
    wr(16'h1000, 8'h5A);
    op_end(60);
    rd(16'h1000);
    chk(v, 32'h5A);
    $display("test options done");
    give_verdict;
  end

  // hang guard, the tests need about 10400 cycles
  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    give_verdict;
  end
endmodule
